// ===== pkg/timer_pkg.sv
`default_nettype none
package timer_pkg;
    localparam logic [15:0] port5_direction_addr = 16'hff25;
    localparam logic [15:0] timer0_mode_control_addr = 16'hff2f;
    localparam logic [15:0] timer1_mode_control_addr = 16'hff3f;
    localparam logic [15:0] timer0_clock_select_addr = 16'hff2e;
    localparam logic [15:0] timer1_clock_select_addr = 16'hff3e;
    localparam logic [15:0] timer0_match_value_addr = 16'hff2d;
    localparam logic [15:0] timer1_match_value_addr = 16'hff3d;
    localparam logic [7:0] mode_control_reset = 8'h00;
    localparam logic [7:0] direction_reset = 8'hff;
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [7:0] mode_control_write_mask = 8'hcf;
    localparam logic [7:0] mode_control_read_mask = 8'hc3;
    localparam logic [7:0] clock_select_mask = 8'h07;
    localparam int run_bit = 7;
    localparam int mode_bit = 6;
    localparam int preset_high_bit = 3;
    localparam int preset_low_bit = 2;
    localparam int toggle_level_bit = 1;
    localparam int pin_enable_bit = 0;
    // count clock source codes; external edge codes use the event pin
    localparam logic [2:0] clk_event_fall = 3'h0;
    localparam logic [2:0] clk_event_rise = 3'h1;
    localparam int prescale_width = 13;
    localparam int num_timers = 2;
endpackage : timer_pkg
`default_nettype wire

// ===== core/timer_pair.sv
// How it works
// - reset clears mode control: stopped, clear-on-match, pin output disabled.
// - bit 7 runs the counter; clearing it zeroes and holds the counter.
// - bit 6 chooses clear-on-match (0) or free-running PWM (1).
// - bits 3/2 preset the output flip-flop: 01 low, 10 high, 00 none.
// - bit 1 toggles on match, or sets PWM active-low level.
// - bit 0 enables the pin output; disabled drives it low.
// - presets act only outside PWM mode.
// - stopping the count in PWM forces the inactive level.
// - preset bits always read back zero.
// - control bits reach the pin whether or not counting runs.
// - mode control takes whole-byte and single-bit writes.
// - direction bits: 0 output, 1 input; reset sets all ones.
// - outside PWM, on match the counter clears, keeps counting, pulses the interrupt.
// - match period is compare value plus one count clocks.
// - count clock comes from the low three clock-select bits.
// - counter steps on every clock (code 2), on each falling edge of the selected prescaler bit, or on the chosen edge of the event pin.
// - stopping or reset zeroes the counter.
// - outside PWM, match raises the interrupt.
`default_nettype none
module timer_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] ctrl,
    input wire logic [2:0] clk_sel,
    input wire logic [7:0] match_value,
    input wire logic [timer_pkg::prescale_width-1:0] prescale,
    input wire logic [timer_pkg::prescale_width-1:0] prescale_nxt,
    input wire logic event_in,
    input wire logic preset_hi,
    input wire logic preset_lo,
    output logic [7:0] up_counter,
    output logic match_interrupt,
    output logic timer_output_pin
);
    logic [7:0] count_r;
    logic event_r;
    logic tick;
    logic out_ff_r;
    logic pwm_ff_r;
    logic match_int_r;
    logic pin_r;
    logic run;
    logic pwm;
    logic match;
    logic [7:0] count_nxt;
    logic pin_nxt;

    assign run = ctrl[timer_pkg::run_bit];
    assign pwm = ctrl[timer_pkg::mode_bit];
    assign match = (count_r == match_value);

    // ------------------------------------------------------------
    // count clock select
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            event_r <= 1'b0;
        else
            event_r <= event_in;
    end

    always_comb
    begin
        case (clk_sel)
            timer_pkg::clk_event_fall: tick = event_r & ~event_in;
            timer_pkg::clk_event_rise: tick = ~event_r & event_in;
            3'h2: tick = 1'b1;
            3'h3: tick = prescale[1] & ~prescale_nxt[1];
            3'h4: tick = prescale[3] & ~prescale_nxt[3];
            3'h5: tick = prescale[5] & ~prescale_nxt[5];
            3'h6: tick = prescale[7] & ~prescale_nxt[7];
            default: tick = prescale[12] & ~prescale_nxt[12];
        endcase
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb
    begin
        count_nxt = count_r;
        if (!run)
            count_nxt = timer_pkg::byte_zero;
        else if (tick)
        begin
            if (!pwm && match)
                count_nxt = timer_pkg::byte_zero;
            else
                count_nxt = count_r + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            count_r <= timer_pkg::byte_zero;
        else
            count_r <= count_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            match_int_r <= 1'b0;
        else
            match_int_r <= run && tick && !pwm && match;
    end

    // ------------------------------------------------------------
    // output flip-flop and pwm
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            out_ff_r <= 1'b0;
        else if (!pwm && preset_lo && !preset_hi)
            out_ff_r <= 1'b0;
        else if (!pwm && preset_hi && !preset_lo)
            out_ff_r <= 1'b1;
        else if (!pwm && run && tick && match && ctrl[timer_pkg::toggle_level_bit])
            out_ff_r <= ~out_ff_r;
    end

    // active from overflow until the count reaches compare: width is compare counts
    // end test wins over overflow, so compare zero never goes active
    always_ff @(posedge clk)
    begin
        if (rst)
            pwm_ff_r <= 1'b0;
        else if (!run || !pwm)
            pwm_ff_r <= 1'b0;
        else if (tick && count_nxt == match_value)
            pwm_ff_r <= 1'b0;
        else if (tick && count_r == 8'hff)
            pwm_ff_r <= 1'b1;
    end

    always_comb
    begin
        if (!ctrl[timer_pkg::pin_enable_bit])
            pin_nxt = 1'b0;
        else if (pwm)
            pin_nxt = pwm_ff_r ^ ctrl[timer_pkg::toggle_level_bit];
        else
            pin_nxt = out_ff_r;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            pin_r <= 1'b0;
        else
            pin_r <= pin_nxt;
    end

    assign up_counter = count_r;
    assign match_interrupt = match_int_r;
    assign timer_output_pin = pin_r;

    a_stop_clears: assert property (@(posedge clk) disable iff (rst)
        !run |=> count_r == 8'h00) else $error("counter not cleared when stopped");
    a_match_pulse: assert property (@(posedge clk) disable iff (rst)
        (run && tick && !pwm && match) |=> match_int_r && count_r == 8'h00)
        else $error("match did not clear and interrupt");
    a_pin_disabled: assert property (@(posedge clk) disable iff (rst)
        !ctrl[timer_pkg::pin_enable_bit] |=> !pin_r)
        else $error("disabled pin not low");
    a_pwm_stop_idle: assert property (@(posedge clk) disable iff (rst)
        (pwm && !run) |=> !pwm_ff_r) else $error("pwm active while stopped");
    a_no_int_pwm: assert property (@(posedge clk) disable iff (rst)
        pwm |=> !match_int_r) else $error("interrupt in pwm mode");
    a_preset_low: assert property (@(posedge clk) disable iff (rst)
        (!pwm && preset_lo && !preset_hi) |=> !out_ff_r)
        else $error("preset low ignored");
    sequence s_preset_high_pwm;
        pwm && preset_hi && !preset_lo;
    endsequence
    a_pwm_preset_ignored: assert property (@(posedge clk) disable iff (rst)
        s_preset_high_pwm |=> out_ff_r == $past(out_ff_r))
        else $error("preset acted in pwm mode");
    a_zero_compare: assert property (@(posedge clk) disable iff (rst)
        (run && !pwm && match_value == 8'h00 && count_r == 8'h00 && tick)
        |=> match_int_r) else $error("compare zero missed");
endmodule : timer_unit

module timer_pair (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_bit_write,
    input wire logic [2:0] reg_bit_index,
    input wire logic reg_read,
    input wire logic [1:0] event_input_pin,
    output logic [7:0] reg_rdata,
    output logic [7:0] port5_direction,
    output logic [1:0] match_interrupt,
    output logic [1:0] timer_output_pin
);
    logic [7:0] mode_r [timer_pkg::num_timers];
    logic [7:0] clk_sel_r [timer_pkg::num_timers];
    logic [7:0] match_r [timer_pkg::num_timers];
    logic [7:0] dir_r;
    logic [7:0] rdata_r;
    logic [timer_pkg::prescale_width-1:0] prescale_r;
    logic [timer_pkg::prescale_width-1:0] prescale_nxt;
    logic [7:0] counter_w [timer_pkg::num_timers];
    logic [1:0] int_w;
    logic [1:0] pin_w;
    logic [7:0] wvalue [timer_pkg::num_timers];
    logic [7:0] dir_wvalue;
    logic [15:0] mode_addr [timer_pkg::num_timers];
    logic [15:0] sel_addr [timer_pkg::num_timers];
    logic [15:0] cmp_addr [timer_pkg::num_timers];
    logic [1:0] ps_hi;
    logic [1:0] ps_lo;

    assign mode_addr[0] = timer_pkg::timer0_mode_control_addr;
    assign mode_addr[1] = timer_pkg::timer1_mode_control_addr;
    assign sel_addr[0] = timer_pkg::timer0_clock_select_addr;
    assign sel_addr[1] = timer_pkg::timer1_clock_select_addr;
    assign cmp_addr[0] = timer_pkg::timer0_match_value_addr;
    assign cmp_addr[1] = timer_pkg::timer1_match_value_addr;
    assign prescale_nxt = prescale_r + 13'h0001;

    always_ff @(posedge clk)
    begin
        if (rst)
            prescale_r <= '0;
        else
            prescale_r <= prescale_nxt;
    end

    // bit writes change one bit of the held value only
    always_comb
    begin
        dir_wvalue = reg_wdata;
        if (reg_bit_write)
        begin
            dir_wvalue = dir_r;
            dir_wvalue[reg_bit_index] = reg_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            dir_r <= timer_pkg::direction_reset;
        else if ((reg_write || reg_bit_write) && reg_addr == timer_pkg::port5_direction_addr)
            dir_r <= dir_wvalue;
    end

    genvar g;
    generate
        for (g = 0; g < timer_pkg::num_timers; g++)
        begin : g_timer
            // presets are pulses: the stored copy reads as zero
            always_comb
            begin
                wvalue[g] = reg_wdata;
                if (reg_bit_write)
                begin
                    wvalue[g] = mode_r[g];
                    wvalue[g][reg_bit_index] = reg_wdata[0];
                end
            end

            assign ps_hi[g] = (reg_write || reg_bit_write) && reg_addr == mode_addr[g]
                && wvalue[g][timer_pkg::preset_high_bit];
            assign ps_lo[g] = (reg_write || reg_bit_write) && reg_addr == mode_addr[g]
                && wvalue[g][timer_pkg::preset_low_bit];

            always_ff @(posedge clk)
            begin
                if (rst)
                    mode_r[g] <= timer_pkg::mode_control_reset;
                else if ((reg_write || reg_bit_write) && reg_addr == mode_addr[g])
                    mode_r[g] <= wvalue[g] & timer_pkg::mode_control_read_mask;
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    clk_sel_r[g] <= timer_pkg::byte_zero;
                    match_r[g] <= timer_pkg::byte_zero;
                end
                else if (reg_write && reg_addr == sel_addr[g])
                    clk_sel_r[g] <= reg_wdata & timer_pkg::clock_select_mask;
                else if (reg_write && reg_addr == cmp_addr[g])
                    match_r[g] <= reg_wdata;
            end

            timer_unit u_timer (
                .clk(clk),
                .rst(rst),
                .ctrl(mode_r[g]),
                .clk_sel(clk_sel_r[g][2:0]),
                .match_value(match_r[g]),
                .prescale(prescale_r),
                .prescale_nxt(prescale_nxt),
                .event_in(event_input_pin[g]),
                .preset_hi(ps_hi[g]),
                .preset_lo(ps_lo[g]),
                .up_counter(counter_w[g]),
                .match_interrupt(int_w[g]),
                .timer_output_pin(pin_w[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_r <= timer_pkg::byte_zero;
        else if (reg_read)
        begin
            rdata_r <= timer_pkg::byte_zero;
            if (reg_addr == timer_pkg::port5_direction_addr)
                rdata_r <= dir_r;
            for (int i = 0; i < timer_pkg::num_timers; i++)
            begin
                if (reg_addr == mode_addr[i])
                    rdata_r <= mode_r[i];
                if (reg_addr == sel_addr[i])
                    rdata_r <= clk_sel_r[i];
                if (reg_addr == cmp_addr[i])
                    rdata_r <= match_r[i];
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign port5_direction = dir_r;
    assign match_interrupt = int_w;
    assign timer_output_pin = pin_w;

    a_dir_reset: assert property (@(posedge clk)
        $fell(rst) |-> dir_r == 8'hff) else $error("direction not all ones after reset");
    a_preset_reads_zero: assert property (@(posedge clk) disable iff (rst)
        (mode_r[0][3:2] == 2'b00) && (mode_r[1][3:2] == 2'b00))
        else $error("preset bits stored");
endmodule : timer_pair
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_bit_write;
    logic [2:0] reg_bit_index;
    logic reg_read;
    logic [1:0] event_input_pin;
    logic [7:0] reg_rdata;
    logic [7:0] port5_direction;
    logic [1:0] match_interrupt;
    logic [1:0] timer_output_pin;
    logic [7:0] rv;
    int fail_count;
    int num_checks;
    int cycles;

    timer_pair u_timer_pair (
        .clk(clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_bit_write(reg_bit_write),
        .reg_bit_index(reg_bit_index),
        .reg_read(reg_read),
        .event_input_pin(event_input_pin),
        .reg_rdata(reg_rdata),
        .port5_direction(port5_direction),
        .match_interrupt(match_interrupt),
        .timer_output_pin(timer_output_pin)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] mc(input int t);
        return t ? timer_pkg::timer1_mode_control_addr : timer_pkg::timer0_mode_control_addr;
    endfunction : mc

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr

    task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic d);
        @(negedge clk);
        reg_addr = a;
        reg_bit_index = i;
        reg_wdata = {7'h00, d};
        reg_bit_write = 1'b1;
        @(negedge clk);
        reg_bit_write = 1'b0;
    endtask : bw

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd_chk

    // pin settles two edges after the write; two spare for margin
    task automatic pin_is(input int t, input logic e);
        repeat (3) @(negedge clk);
        check({15'h0000, timer_output_pin[t]}, {15'h0000, e});
    endtask : pin_is

    task automatic wait_irq(input int t, output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (match_interrupt[t] !== 1'b1 && n < 9000);
    endtask : wait_irq

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(mc(0), 8'h00);
        rd_chk(mc(1), 8'h00);
        rd_chk(timer_pkg::port5_direction_addr, 8'hff);
        check({8'h00, port5_direction}, 16'h00ff);
        check({14'h0000, timer_output_pin}, 16'h0000);
        rd_chk(16'hff00, 8'h00);
        wr(timer_pkg::port5_direction_addr, 8'hfc);
        check({8'h00, port5_direction}, 16'h00fc);
        rd_chk(timer_pkg::port5_direction_addr, 8'hfc);
    endtask : t_reset

    task automatic t_presets(input int t);
        wr(mc(t), 8'h01);
        wr(mc(t), 8'h09);
        pin_is(t, 1'b1);
        rd_chk(mc(t), 8'h01);
        wr(mc(t), 8'h05);
        pin_is(t, 1'b0);
        wr(mc(t), 8'h09);
        wr(mc(t), 8'h0d);
        pin_is(t, 1'b1);
        wr(mc(t), 8'h00);
        pin_is(t, 1'b0);
        wr(mc(t), 8'h01);
        pin_is(t, 1'b1);
        wr(mc(t), 8'h05);
        wr(mc(t), 8'h00);
    endtask : t_presets

    // div: clocks per count clock for the chosen source
    task automatic t_interval(input int t, input logic [7:0] n, input logic [7:0] sel,
        input int div);
        int p;
        wr(mc(t) - 16'h0001, sel);
        wr(mc(t) - 16'h0002, n);
        wr(mc(t), 8'h00);
        rd_chk(mc(t) - 16'h0002, n);
        bw(mc(t), 3'h7, 1'b1);
        rd_chk(mc(t), 8'h80);
        wait_irq(t, p);
        wait_irq(t, p);
        check(16'(p), 16'((int'(n) + 1) * div));
        wr(mc(t), 8'h00);
        repeat (2) @(negedge clk);
        p = 0;
        repeat (300)
        begin
            @(negedge clk);
            p += int'(match_interrupt[t]);
        end
        check(16'(p), 16'h0000);
    endtask : t_interval

    task automatic t_toggle();
        int p;
        logic first;
        wr(timer_pkg::timer0_clock_select_addr, 8'h02);
        wr(timer_pkg::timer0_match_value_addr, 8'h03);
        wr(mc(0), 8'h01);
        wr(mc(0), 8'h05);
        wr(mc(0), 8'h03);
        wr(mc(0), 8'h83);
        wait_irq(0, p);
        repeat (2) @(negedge clk);
        first = timer_output_pin[0];
        check({15'h0000, first}, 16'h0001);
        wait_irq(0, p);
        repeat (2) @(negedge clk);
        check({15'h0000, timer_output_pin[0]}, {15'h0000, ~first});
        wr(mc(0), 8'h03);
        wr(mc(0), 8'h01);
        wr(mc(0), 8'h00);
    endtask : t_toggle

    task automatic t_pwm(input int t);
        int hi;
        wr(mc(t) - 16'h0001, 8'h02);
        wr(mc(t) - 16'h0002, 8'h80);
        wr(mc(t), 8'h40);
        wr(mc(t), 8'h41);
        pin_is(t, 1'b0);
        wr(mc(t), 8'h49);
        pin_is(t, 1'b0);
        wr(mc(t), 8'hc1);
        repeat (300) @(negedge clk);
        hi = 0;
        repeat (256)
        begin
            @(negedge clk);
            hi += int'(timer_output_pin[t]);
        end
        check(16'(hi), 16'h0080);
        wr(mc(t), 8'h41);
        pin_is(t, 1'b0);
        wr(mc(t), 8'h43);
        pin_is(t, 1'b1);
        wr(mc(t), 8'h47);
        pin_is(t, 1'b1);
        rd_chk(mc(t), 8'h43);
        wr(mc(t), 8'h41);
        wr(mc(t), 8'h40);
        wr(mc(t), 8'h00);
    endtask : t_pwm

    // nine edges of the chosen polarity, compare 2: three matches
    task automatic t_event(input int t, input logic [7:0] sel);
        int p;
        bw(timer_pkg::port5_direction_addr, 3'(t), 1'b1);
        check({15'h0000, port5_direction[t]}, 16'h0001);
        wr(mc(t) - 16'h0001, sel);
        wr(mc(t) - 16'h0002, 8'h02);
        wr(mc(t), 8'h80);
        p = 0;
        repeat (9)
        begin
            repeat (3)
            begin
                @(negedge clk);
                event_input_pin[t] = 1'b1;
                p += int'(match_interrupt[t]);
            end
            repeat (3)
            begin
                @(negedge clk);
                event_input_pin[t] = 1'b0;
                p += int'(match_interrupt[t]);
            end
        end
        check(16'(p), 16'h0003);
        wr(mc(t), 8'h00);
    endtask : t_event

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_bit_write = 1'b0;
        reg_bit_index = 3'h0;
        reg_read = 1'b0;
        event_input_pin = 2'b00;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_reset();
        for (int t = 0; t < 2; t++)
        begin
            t_presets(t);
            t_interval(t, 8'h00, 8'h02, 1);
            t_interval(t, 8'h03, 8'h02, 1);
            t_interval(t, 8'hff, 8'h02, 1);
            t_pwm(t);
        end
        t_interval(0, 8'h03, 8'h03, 4);
        t_interval(0, 8'h03, 8'h04, 16);
        t_interval(1, 8'h00, 8'h05, 64);
        t_interval(1, 8'h00, 8'h06, 256);
        t_interval(0, 8'h00, 8'h07, 8192);
        t_toggle();
        t_event(0, 8'h00);
        t_event(1, 8'h01);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
